//--- logic/msc_consts.svh
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH

// ---------------------------------------------------------------
// management map
// ---------------------------------------------------------------
`define MSC_DEV_ADDR 7'h50
`define MSC_OFS_STATUS 8'h02
`define MSC_OFS_FLAGS 8'h03
`define MSC_OFS_PWR_CTRL 8'h5D
`define MSC_OFS_EXT_ID 8'h81
`define MSC_BIT_DNR 0
`define MSC_BIT_FAULT 0
`define MSC_BIT_PWR_OVR 0
`define MSC_BIT_PWR_SET 1
`define MSC_PCLASS_HI 7
`define MSC_PCLASS_LO 6
`define MSC_PWR_CTRL_RESET 8'h00
// identifier content, power class field nonzero means above 1.5 W
`define MSC_EXT_ID_DEFAULT 8'hC0
`define MSC_PINS_IDLE 5'h1F

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define MSC_CLK_MHZ 40
`define MSC_T_RESET_MIN_NS 2000
`define MSC_RESET_MIN_CYCLES ((`MSC_T_RESET_MIN_NS * `MSC_CLK_MHZ + 999) / 1000)
`define MSC_T_INIT_MS 2000
`define MSC_INIT_CYCLES (`MSC_T_INIT_MS * `MSC_CLK_MHZ * 1000)

`endif

//--- logic/msc_pkg.sv
`default_nettype none

package msc_pkg;

   typedef struct packed {
      logic sel_n;
      logic reset_n;
      logic lp_req;
      logic scl;
      logic sda;
   } msc_pins_t;

   typedef struct packed {
      logic [5:0] unused;
      logic power_set;
      logic power_override;
   } msc_pwr_ctrl_t;

   typedef enum logic [8:0] {
      I2C_IDLE = 9'h001,
      I2C_DEV = 9'h002,
      I2C_DEV_ACK = 9'h004,
      I2C_OFS = 9'h008,
      I2C_OFS_ACK = 9'h010,
      I2C_WR = 9'h020,
      I2C_WR_ACK = 9'h040,
      I2C_RD = 9'h080,
      I2C_RD_ACK = 9'h100
   } msc_i2c_state_t;

   typedef enum logic [2:0] {
      INIT_HOLD = 3'h1,
      INIT_RUN = 3'h2,
      INIT_DONE = 3'h4
   } msc_init_state_t;

endpackage

`default_nettype wire

//--- logic/msc_pin_sync.sv
`include "msc_consts.svh"
`default_nettype none

module msc_pin_sync
   import msc_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire msc_pins_t pins_async,
   output msc_pins_t pins_sync
);

   // idle value is all high: pulled-up pins read deselected and released
   msc_pins_t meta_reg;
   msc_pins_t sync_reg;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         meta_reg <= `MSC_PINS_IDLE; // R03
         sync_reg <= `MSC_PINS_IDLE;
      end
      else if (ce)
      begin
         meta_reg <= pins_async;
         sync_reg <= meta_reg;
      end
   end

   assign pins_sync = sync_reg;

endmodule // msc_pin_sync

`default_nettype wire

//--- logic/msc_sideband_top.sv
`include "msc_consts.svh"
`default_nettype none

// Summary of operation
// [R01] answer management bus only while selected
// [R02] deselected: never acknowledge nor drive data
// [R03] select input idles deselected
// [R04] host waits deselect time before bus use
// [R05] host waits select time before talking
// [R06] qualified reset pin clears all settings
// [R07] init interval timed from reset release
// [R08] host ignores status until completion interrupt
// [R09] completion: interrupt low, not-ready cleared
// [R10] completion interrupt also after power-up
// [R11] low power keeps management and safety
// [R12] low power still posts completion interrupt
// [R13] high class in low power cuts transmit
// [R14] low class stays fully functional
// [R15] override and set bits in byte 93
// [R16] power mode from override, set, pin
// [R17] override and set cleared at power-up
// [R18] presence output grounded inside module
// [R19] interrupt low flags fault or status
// [R20] release interrupt after status and flags read
// [R21] synchronise pins, count reset pulse length
module msc_sideband_top
   import msc_pkg::*;
#(
   parameter int unsigned INIT_CYCLES = `MSC_INIT_CYCLES,
   parameter logic [7:0] EXT_ID = `MSC_EXT_ID_DEFAULT
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic module_select_n,
   input wire logic module_reset_n,
   input wire logic low_power_request_pin,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic fault_event,
   output logic sda_out,
   output logic sda_oe_n,
   output logic interrupt_out,
   output logic interrupt_oe_n,
   output logic presence_n,
   output logic low_power_mode,
   output logic tx_path_enable
);

   localparam logic [7:0] RESET_MIN = 8'(`MSC_RESET_MIN_CYCLES);
   localparam logic [26:0] INIT_LAST = 27'(INIT_CYCLES - 1);

   // ---------------------------------------------------------------
   // pin synchronisers and edges
   // ---------------------------------------------------------------
   msc_pins_t pins_raw;
   msc_pins_t pins_s;
   logic scl_q_reg;
   logic sda_q_reg;
   logic rpin_q_reg;

   assign pins_raw = '{sel_n: module_select_n, reset_n: module_reset_n,
                       lp_req: low_power_request_pin, scl: scl_in, sda: sda_in};

   msc_pin_sync u_sync
   (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .pins_async(pins_raw), // R21
      .pins_sync(pins_s)
   );

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
         rpin_q_reg <= 1'b1;
      end
      else if (ce)
      begin
         scl_q_reg <= pins_s.scl;
         sda_q_reg <= pins_s.sda;
         rpin_q_reg <= pins_s.reset_n;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic rst_rise;

   assign scl_rise = pins_s.scl & ~scl_q_reg;
   assign scl_fall = ~pins_s.scl & scl_q_reg;
   assign start_det = pins_s.scl & scl_q_reg & sda_q_reg & ~pins_s.sda;
   assign stop_det = pins_s.scl & scl_q_reg & ~sda_q_reg & pins_s.sda;
   assign rst_rise = pins_s.reset_n & ~rpin_q_reg;

   // ---------------------------------------------------------------
   // reset pin qualification and init interval
   // ---------------------------------------------------------------
   logic [7:0] low_cnt_reg;
   msc_init_state_t init_state_reg;
   logic [26:0] init_cnt_reg;
   logic qual_low;
   logic init_done_pulse;
   logic dnr;

   always_ff @(posedge clock)
   begin
      if (rst)
         low_cnt_reg <= 8'h00;
      else if (ce)
      begin
         if (pins_s.reset_n)
            low_cnt_reg <= 8'h00;
         else if (low_cnt_reg != RESET_MIN)
            low_cnt_reg <= low_cnt_reg + 8'h01; // R21
      end
   end

   // a glitch shorter than the minimum never reaches the settings
   assign qual_low = ~pins_s.reset_n & (low_cnt_reg == RESET_MIN);

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         init_state_reg <= INIT_RUN; // R10
         init_cnt_reg <= 27'h0000000;
      end
      else if (ce)
      begin
         if (qual_low)
         begin
            init_state_reg <= INIT_HOLD; // R06
            init_cnt_reg <= 27'h0000000;
         end
         else
         begin
            unique case (init_state_reg)
               INIT_HOLD:
               begin
                  if (pins_s.reset_n)
                     init_state_reg <= INIT_RUN; // R07
               end
               INIT_RUN:
               begin
                  if (init_cnt_reg == INIT_LAST)
                     init_state_reg <= INIT_DONE;
                  else
                     init_cnt_reg <= init_cnt_reg + 27'h0000001;
               end
               INIT_DONE:
               begin
               end
            endcase
         end
      end
   end

   assign dnr = (init_state_reg != INIT_DONE);
   assign init_done_pulse = ce & ~qual_low & (init_state_reg == INIT_RUN) &
                            (init_cnt_reg == INIT_LAST);

   // ---------------------------------------------------------------
   // management slave
   // ---------------------------------------------------------------
   msc_i2c_state_t i2c_state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] offset_reg;
   logic rw_reg;
   logic sda_drive_reg;
   logic fault_flag_reg;
   msc_pwr_ctrl_t pwr_ctrl_reg;
   logic engine_go;
   logic load_now;
   logic wr_commit;
   logic [7:0] rd_data;

   function automatic logic [7:0] read_byte(input logic [7:0] ofs, input logic not_ready,
                                            input logic fault, input msc_pwr_ctrl_t ctrl);
      logic [7:0] val;
      val = 8'h00;
      unique case (ofs)
         `MSC_OFS_STATUS: val[`MSC_BIT_DNR] = not_ready;
         `MSC_OFS_FLAGS: val[`MSC_BIT_FAULT] = fault;
         `MSC_OFS_PWR_CTRL: val = ctrl;
         `MSC_OFS_EXT_ID: val = EXT_ID;
         default: val = 8'h00;
      endcase
      return val;
   endfunction

   // deselect, start and stop override any byte in flight
   assign engine_go = ce & ~pins_s.sel_n & ~start_det & ~stop_det; // R01
   assign load_now = engine_go & scl_fall &
                     (((i2c_state_reg == I2C_DEV_ACK) & rw_reg) | (i2c_state_reg == I2C_RD_ACK));
   assign wr_commit = engine_go & scl_fall & (i2c_state_reg == I2C_WR) &
                      (bit_cnt_reg == 4'h8);
   assign rd_data = read_byte(offset_reg, dnr, fault_flag_reg, pwr_ctrl_reg);

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         i2c_state_reg <= I2C_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         offset_reg <= 8'h00;
         rw_reg <= 1'b0;
         sda_drive_reg <= 1'b0;
      end
      else if (ce)
      begin
         if (pins_s.sel_n)
         begin
            i2c_state_reg <= I2C_IDLE; // R02
            sda_drive_reg <= 1'b0;
         end
         else if (start_det)
         begin
            i2c_state_reg <= I2C_DEV; // R01
            bit_cnt_reg <= 4'h0;
            sda_drive_reg <= 1'b0;
         end
         else if (stop_det)
         begin
            i2c_state_reg <= I2C_IDLE;
            sda_drive_reg <= 1'b0;
         end
         else if (load_now)
         begin
            // management stays alive in low power mode
            shift_reg <= rd_data; // R11
            sda_drive_reg <= ~rd_data[7];
            bit_cnt_reg <= 4'h1;
            i2c_state_reg <= I2C_RD;
         end
         else
         begin
            unique case (i2c_state_reg)
               I2C_IDLE:
               begin
               end
               I2C_DEV, I2C_OFS, I2C_WR:
               begin
                  if (scl_rise)
                  begin
                     shift_reg <= {shift_reg[6:0], pins_s.sda};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
                  else if (scl_fall && bit_cnt_reg == 4'h8)
                  begin
                     bit_cnt_reg <= 4'h0;
                     sda_drive_reg <= 1'b1;
                     if (i2c_state_reg == I2C_DEV)
                     begin
                        rw_reg <= shift_reg[0];
                        if (shift_reg[7:1] == `MSC_DEV_ADDR)
                           i2c_state_reg <= I2C_DEV_ACK;
                        else
                        begin
                           i2c_state_reg <= I2C_IDLE;
                           sda_drive_reg <= 1'b0;
                        end
                     end
                     else if (i2c_state_reg == I2C_OFS)
                     begin
                        offset_reg <= shift_reg;
                        i2c_state_reg <= I2C_OFS_ACK;
                     end
                     else
                     begin
                        offset_reg <= offset_reg + 8'h01;
                        i2c_state_reg <= I2C_WR_ACK;
                     end
                  end
               end
               I2C_DEV_ACK, I2C_OFS_ACK, I2C_WR_ACK:
               begin
                  // a read header never gets here: load_now takes it first
                  if (scl_fall)
                  begin
                     sda_drive_reg <= 1'b0;
                     i2c_state_reg <= (i2c_state_reg == I2C_DEV_ACK) ? I2C_OFS : I2C_WR;
                  end
               end
               I2C_RD:
               begin
                  if (scl_fall)
                  begin
                     if (bit_cnt_reg == 4'h8)
                     begin
                        sda_drive_reg <= 1'b0;
                        offset_reg <= offset_reg + 8'h01;
                        i2c_state_reg <= I2C_RD_ACK;
                     end
                     else
                     begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        sda_drive_reg <= ~shift_reg[6];
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     end
                  end
               end
               I2C_RD_ACK:
               begin
                  if (scl_rise && pins_s.sda)
                     i2c_state_reg <= I2C_IDLE;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // power control byte and power mode
   // ---------------------------------------------------------------
   logic lp_next;
   logic class_high;

   always_ff @(posedge clock)
   begin
      if (rst)
         pwr_ctrl_reg <= `MSC_PWR_CTRL_RESET; // R17
      else if (ce)
      begin
         if (init_state_reg == INIT_HOLD)
            pwr_ctrl_reg <= `MSC_PWR_CTRL_RESET; // R06
         else if (wr_commit && offset_reg == `MSC_OFS_PWR_CTRL)
         begin
            pwr_ctrl_reg.power_override <= shift_reg[`MSC_BIT_PWR_OVR]; // R15
            pwr_ctrl_reg.power_set <= shift_reg[`MSC_BIT_PWR_SET];
         end
      end
   end

   assign lp_next = pwr_ctrl_reg.power_override ? pwr_ctrl_reg.power_set
                                                : pins_s.lp_req; // R16
   assign class_high = (EXT_ID[`MSC_PCLASS_HI:`MSC_PCLASS_LO] != 2'b00);

   // only the transmit path is cut; laser safety logic lives outside and is untouched
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         low_power_mode <= 1'b0;
         tx_path_enable <= 1'b1;
      end
      else if (ce)
      begin
         low_power_mode <= lp_next;
         tx_path_enable <= ~(lp_next & class_high); // R13 R14
      end
   end

   // ---------------------------------------------------------------
   // fault flag and interrupt
   // ---------------------------------------------------------------
   logic int_active_reg;
   logic status_seen_reg;
   logic flags_seen_reg;
   logic int_set;

   assign int_set = init_done_pulse | (ce & fault_event);

   always_ff @(posedge clock)
   begin
      if (rst)
         fault_flag_reg <= 1'b0;
      else if (ce)
      begin
         if (fault_event)
            fault_flag_reg <= 1'b1; // R19
         else if ((init_state_reg == INIT_HOLD) ||
                  (load_now && offset_reg == `MSC_OFS_FLAGS))
            fault_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         status_seen_reg <= 1'b0;
         flags_seen_reg <= 1'b0;
      end
      else if (ce)
      begin
         if (int_set || init_state_reg == INIT_HOLD)
         begin
            status_seen_reg <= 1'b0;
            flags_seen_reg <= 1'b0;
         end
         else if (load_now)
         begin
            if (offset_reg == `MSC_OFS_STATUS && !dnr)
               status_seen_reg <= 1'b1; // R20
            if (offset_reg == `MSC_OFS_FLAGS && !dnr)
               flags_seen_reg <= 1'b1;
         end
      end
   end

   // a new event in the release cycle keeps the line low
   always_ff @(posedge clock)
   begin
      if (rst)
         int_active_reg <= 1'b0;
      else if (ce)
      begin
         if (int_set)
            int_active_reg <= 1'b1; // R09 R12
         else if (init_state_reg == INIT_HOLD)
            int_active_reg <= 1'b0;
         else if (status_seen_reg && flags_seen_reg)
            int_active_reg <= 1'b0; // R20
      end
   end

   // ---------------------------------------------------------------
   // pins out
   // ---------------------------------------------------------------
   assign sda_out = 1'b0;
   assign sda_oe_n = ~sda_drive_reg;
   assign interrupt_out = 1'b0;
   assign interrupt_oe_n = ~int_active_reg;
   assign presence_n = 1'b0; // R18

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   a_desel_release: assert property ((ce && pins_s.sel_n) |=> sda_oe_n) // R02
      else $error("data line driven while deselected");
   a_desel_idle: assert property ((ce && pins_s.sel_n) |=> i2c_state_reg == I2C_IDLE) // R01
      else $error("engine active while deselected");
   a_power_mode: assert property (ce |=> low_power_mode == $past(lp_next)) // R16
      else $error("power mode not from override, set and pin");
   a_tx_cut: assert property ((ce && lp_next && class_high) |=> !tx_path_enable) // R13
      else $error("transmit path left on in low power");
   a_full_func: assert property (!class_high |-> tx_path_enable) // R14
      else $error("low class module lost transmit path");
   a_powerup_clear: assert property ($fell(rst) |-> pwr_ctrl_reg == `MSC_PWR_CTRL_RESET) // R17
      else $error("power control bits not cleared at power-up");
   a_reset_clears: assert property ((ce && qual_low) |=> ##1 pwr_ctrl_reg == 8'h00 && dnr) // R06
      else $error("qualified reset did not clear settings");
   a_short_pulse: assert property ((ce && rst_rise && low_cnt_reg != RESET_MIN && !dnr)
                                   |=> !dnr) // R21
      else $error("short reset pulse started a reset");
   a_init_start: assert property ((ce && init_state_reg == INIT_HOLD && !qual_low &&
                                   pins_s.reset_n) |=> init_state_reg == INIT_RUN &&
                                   init_cnt_reg == 27'h0000000) // R07
      else $error("init interval not started at release");
   a_done_int: assert property (init_done_pulse |=> !dnr && !interrupt_oe_n) // R09
      else $error("completion without interrupt and ready");
   a_int_release: assert property ($rose(interrupt_oe_n) |->
                                   ($past(status_seen_reg) && $past(flags_seen_reg)) ||
                                   ($past(init_state_reg) == INIT_HOLD)) // R20
      else $error("interrupt released without status and flag reads");

   c_write_ctrl: cover property (wr_commit && offset_reg == `MSC_OFS_PWR_CTRL);
   c_qual_reset: cover property (init_state_reg == INIT_HOLD ##1 init_state_reg == INIT_RUN);
   c_int_release: cover property ($rose(interrupt_oe_n));
   c_low_power: cover property (low_power_mode && !tx_path_enable);

endmodule // msc_sideband_top

`default_nettype wire

//--- verification/msc_host_model.sv
`default_nettype none

module msc_host_model
(
   input wire logic clock,
   input wire logic dev_sda_out,
   input wire logic dev_sda_oe_n,
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 100ps;

   localparam int HALF = 8;

   logic sda_drv;

   // open-drain wire, host pull-up wins when nobody pulls low
   assign sda = sda_drv & (dev_sda_oe_n | dev_sda_out);

   initial
   begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   // ---------------------------------------------------------------
   // bus phases
   // ---------------------------------------------------------------
   // half period well above the six clocks the slave needs
   task automatic hp;
      repeat (HALF) @(posedge clock);
      #2;
   endtask

   // also serves as repeated start from clock low
   task automatic start;
      sda_drv = 1'b1;
      hp();
      scl = 1'b1;
      hp();
      sda_drv = 1'b0;
      hp();
      scl = 1'b0;
      hp();
   endtask

   task automatic stop;
      sda_drv = 1'b0;
      hp();
      scl = 1'b1;
      hp();
      sda_drv = 1'b1;
      hp();
   endtask

   // sampled at the end of clock high, where the slave bit stands
   task automatic bit_io(input logic b, output logic r);
      sda_drv = b;
      hp();
      scl = 1'b1;
      hp();
      r = sda;
      scl = 1'b0;
   endtask

   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
      output logic ack);
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(d[i], q[i]);
      end
      bit_io(ack_in, ack);
   endtask

endmodule // msc_host_model

`default_nettype wire

//--- verification/module_sideband_control_tb.sv
`default_nettype none

module module_sideband_control_tb;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int INIT = 200;

   logic clock, rst, ce, sel_n, rst_n, lp_pin, fault, scl, sda, e;
   logic lp_mode2, tx_en2;
   logic sda_out, sda_oe_n, int_out, int_oe_n, prs_n, lp_mode, tx_en;
   logic [7:0] q;
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;

   msc_sideband_top #(.INIT_CYCLES(INIT), .EXT_ID(8'hC0)) i_msc_sideband_top (
      .clock(clock), .rst(rst), .ce(ce), .module_select_n(sel_n),
      .module_reset_n(rst_n), .low_power_request_pin(lp_pin), .scl_in(scl),
      .sda_in(sda), .fault_event(fault), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .interrupt_out(int_out), .interrupt_oe_n(int_oe_n), .presence_n(prs_n),
      .low_power_mode(lp_mode), .tx_path_enable(tx_en));

   // low class twin in lockstep, only its power outputs are watched
   msc_sideband_top #(.INIT_CYCLES(INIT), .EXT_ID(8'h00)) i_msc_sideband_top_lc (
      .clock(clock), .rst(rst), .ce(ce), .module_select_n(sel_n),
      .module_reset_n(rst_n), .low_power_request_pin(lp_pin), .scl_in(scl),
      .sda_in(sda), .fault_event(fault), .sda_out(), .sda_oe_n(),
      .interrupt_out(), .interrupt_oe_n(), .presence_n(),
      .low_power_mode(lp_mode2), .tx_path_enable(tx_en2));

   msc_host_model i_msc_host_model (.clock(clock), .dev_sda_out(sda_out),
      .dev_sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));

   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic give_verdict;
      if (error_cnt == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // roughly 16k cycles expected, ceiling leaves margin
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         error_cnt++;
         give_verdict();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask

   task automatic wait_int(input int n);
      int k;
      k = 0;
      while (int_oe_n !== 1'b0 && k < n)
      begin
         cycles(1);
         k++;
      end
      chk({7'h00, int_oe_n}, 8'h00);
   endtask

   task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] d, input logic nak);
      logic [7:0] x;
      logic a0, a1, a2;
      i_msc_host_model.start();
      i_msc_host_model.xfer(8'hA0, 1'b1, x, a0);
      i_msc_host_model.xfer(ofs, 1'b1, x, a1);
      i_msc_host_model.xfer(d, 1'b1, x, a2);
      i_msc_host_model.stop();
      chk({5'h00, a0, a1, a2}, nak ? 8'h07 : 8'h00);
   endtask

   task automatic reg_rd(input logic [7:0] ofs, output logic [7:0] d);
      logic [7:0] x;
      logic a0, a1, a2, a3;
      i_msc_host_model.start();
      i_msc_host_model.xfer(8'hA0, 1'b1, x, a0);
      i_msc_host_model.xfer(ofs, 1'b1, x, a1);
      i_msc_host_model.start();
      i_msc_host_model.xfer(8'hA1, 1'b1, x, a2);
      i_msc_host_model.xfer(8'hFF, 1'b1, d, a3);
      i_msc_host_model.stop();
      chk({5'h00, a0, a1, a2}, 8'h00);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      sel_n = 1'b1;
      rst_n = 1'b1;
      lp_pin = 1'b0;
      fault = 1'b0;
      repeat (12) @(posedge clock);
      #2;
      chk({5'h00, prs_n, int_oe_n, int_out}, 8'h02);
      rst = 1'b0;
      chk({6'h00, lp_mode, tx_en}, 8'h01);
      wait_int(INIT + 20);
      sel_n = 1'b0;
      cycles(10);
      reg_rd(8'h02, q);
      chk(q & 8'h01, 8'h00);
      chk({7'h00, int_oe_n}, 8'h00);
      reg_rd(8'h81, q);
      chk(q, 8'hC0);
      reg_rd(8'h03, q);
      cycles(3);
      chk({7'h00, int_oe_n}, 8'h01);
      for (int i = 0; i < 8; i++)
      begin
         lp_pin = i[2];
         reg_wr(8'h5D, {6'h00, i[1:0]}, 1'b0);
         cycles(8);
         e = i[0] ? i[1] : i[2];
         chk({6'h00, lp_mode, tx_en}, {6'h00, e, !e});
         chk({6'h00, lp_mode2, tx_en2}, {6'h00, e, 1'b1});
         reg_rd(8'h5D, q);
         chk(q, {6'h00, i[1:0]});
      end
      fault = 1'b1;
      cycles(1);
      fault = 1'b0;
      cycles(3);
      chk({7'h00, int_oe_n}, 8'h00);
      reg_rd(8'h03, q);
      chk(q & 8'h01, 8'h01);
      reg_rd(8'h02, q);
      cycles(3);
      chk({7'h00, int_oe_n}, 8'h01);
      // frozen clock enable must swallow a fault pulse
      ce = 1'b0;
      fault = 1'b1;
      cycles(2);
      fault = 1'b0;
      ce = 1'b1;
      cycles(3);
      chk({7'h00, int_oe_n}, 8'h01);
      sel_n = 1'b1;
      cycles(10);
      reg_wr(8'h5D, 8'h00, 1'b1);
      sel_n = 1'b0;
      cycles(10);
      reg_rd(8'h5D, q);
      chk(q, 8'h03);
      // pulse shorter than the qualifying length must be ignored
      rst_n = 1'b0;
      cycles(20);
      rst_n = 1'b1;
      cycles(10);
      reg_rd(8'h5D, q);
      chk(q, 8'h03);
      rst_n = 1'b0;
      cycles(100);
      rst_n = 1'b1;
      cycles(INIT - 20);
      chk({7'h00, int_oe_n}, 8'h01);
      wait_int(40);
      chk({6'h00, lp_mode, tx_en}, 8'h02);
      reg_rd(8'h5D, q);
      chk(q, 8'h00);
      reg_rd(8'h02, q);
      chk(q & 8'h01, 8'h00);
      give_verdict();
   end

endmodule // module_sideband_control_tb

`default_nettype wire
